// [design/reset_ctrl_pkg.sv]
package reset_ctrl_pkg;
  // Register byte addresses on the peripheral bus
  localparam logic [31:0] RETENTION_CONFIG_ADDR = 32'h4000_2408;
  localparam logic [31:0] CONFIG_KEY_ADDR = 32'h4000_240C;
  localparam logic [31:0] CAUSE_FLAGS_ADDR = 32'h4000_2440;
  localparam logic [31:0] ANALOG_RETENTION_ADDR = 32'h4008_2C34;
  // Reset values
  localparam logic [15:0] REG_RESET_VALUE = 16'h0000;
  // Key sequence and core reset request key
  localparam logic [15:0] KEY_FIRST = 16'h2009;
  localparam logic [15:0] KEY_SECOND = 16'h0426;
  localparam logic [15:0] CORE_RESET_KEY = 16'h05FA;
  localparam int CORE_KEY_LSB = 16;
  // Cause flag positions
  localparam int POR_BIT = 0;
  localparam int PIN_BIT = 1;
  localparam int WDOG_BIT = 2;
  localparam int SOFT_BIT = 3;
  localparam int CAUSE_WIDTH = 4;
  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PIN_HIGHZ_TIME_US = 260;
  localparam int PIN_HIGHZ_CYCLES = PIN_HIGHZ_TIME_US * 1000000 / CLK_PERIOD_PS;
  localparam int WDOG_TIMEOUT_S = 32;

  typedef enum logic [2:0] {
    KEY_LOCKED = 3'h1,
    KEY_HALF = 3'h2,
    KEY_OPEN = 3'h4
  } key_state_type;

  // Register write strobe bundle from the core side
  typedef struct packed {
    logic wr;
    logic [31:0] addr;
    logic [15:0] data;
  } reg_write_type;

  // Retention controls towards the rest of the chip
  typedef struct packed {
    logic pins_reset;
    logic analog_reset;
    logic mmr_reset;
    logic sram_valid;
  } retention_out_type;
endpackage

// [design/reset_cause_and_retention_control.sv]
`timescale 1ns/10ps
// Overview of operation
// - Four reset causes: pin, power-on, watchdog, software
// - Core key 0x05FA upper half requests reset
// - Analog state kept by default, config disables
// - Analog bit0: 0 keep, 1 reset
// - Pins and logic kept; write 1 resets
// - Retention bit0: 1 reset, 0 keep
// - Retained pin tri-stated 260 us after reset
// - Retention config write needs keys 0x2009 then 0x0426
// - Any other bus write relocks the key
// - Cause flags survive non-power-on resets
// - Each reset sets its own cause flag
// - Write one clears flag; upper bits zero
// - Hard resets reset pins, logic, analog; soft ones per retention
// - Watchdog enabled after every reset
module reset_cause_and_retention_control #(
  parameter int HIGHZ_CYCLES = reset_ctrl_pkg::PIN_HIGHZ_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic por_i,
  input wire logic pin_reset_n_i,
  input wire logic wdog_timeout_i,
  input wire logic core_ctrl_wr_i,
  input wire logic [31:0] core_ctrl_data_i,
  input wire reset_ctrl_pkg::reg_write_type bus_wr_i,
  input wire logic [31:0] bus_rd_addr_i,
  output logic [15:0] bus_rd_data_o,
  output logic system_reset_o,
  output reset_ctrl_pkg::retention_out_type retention_o,
  output logic pin_p3_4_oe_n_o,
  output logic wdog_enable_o
);
  import reset_ctrl_pkg::*;

  // Pin reset is asynchronous to the core clock
  logic pin_meta, pin_sync;
  always_ff @(posedge clk_sys_i) begin
    pin_meta <= ~pin_reset_n_i;
    pin_sync <= pin_meta;
  end

  // Decoded write strobes
  wire wr_cfg = bus_wr_i.wr && bus_wr_i.addr == RETENTION_CONFIG_ADDR;
  wire wr_key = bus_wr_i.wr && bus_wr_i.addr == CONFIG_KEY_ADDR;
  wire wr_cause = bus_wr_i.wr && bus_wr_i.addr == CAUSE_FLAGS_ADDR;
  wire wr_analog = bus_wr_i.wr && bus_wr_i.addr == ANALOG_RETENTION_ADDR;
  wire soft_req = core_ctrl_wr_i && core_ctrl_data_i[31:CORE_KEY_LSB] == CORE_RESET_KEY;
  wire wdog_req = wdog_timeout_i;

  // Reset event vector; power-on dominates, all four causes accepted
  logic [CAUSE_WIDTH-1:0] events;
  assign events = {soft_req, wdog_req, pin_sync, por_i};

  logic [CAUSE_WIDTH-1:0] cause;
  logic pins_reset, analog_reset;
  key_state_type key_state, next_key_state;
  logic [15:0] key_reg;
  wire hard_reset = por_i | pin_sync;
  wire soft_reset = soft_req | wdog_req;

  // Cause flags: power-on clears all but its own, set wins over write-one clear
  genvar g;
  generate
    for (g = 0; g < CAUSE_WIDTH; g++) begin : g_cause
      always_ff @(posedge clk_sys_i) begin
        if (por_i && g != POR_BIT) begin
          cause[g] <= 1'b0;
        end else if (events[g]) begin
          cause[g] <= 1'b1;
        end else if (wr_cause && bus_wr_i.data[g]) begin
          cause[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Key sequencer; a foreign write anywhere relocks
  always_comb begin
    next_key_state = key_state;
    case (key_state)
      KEY_LOCKED: begin
        if (wr_key && bus_wr_i.data == KEY_FIRST) next_key_state = KEY_HALF;
      end
      KEY_HALF: begin
        if (wr_key && bus_wr_i.data == KEY_SECOND) next_key_state = KEY_OPEN;
        else if (bus_wr_i.wr) next_key_state = KEY_LOCKED;
      end
      KEY_OPEN: begin
        if (bus_wr_i.wr) next_key_state = KEY_LOCKED;
      end
      default: next_key_state = KEY_LOCKED;
    endcase
  end

  // Config registers; hard resets restore, soft ones only where not retained
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || hard_reset) begin
      key_state <= KEY_LOCKED;
      key_reg <= REG_RESET_VALUE;
      pins_reset <= REG_RESET_VALUE[0];
      analog_reset <= REG_RESET_VALUE[0];
    end else begin
      key_state <= soft_reset ? KEY_LOCKED : next_key_state;
      if (wr_key) key_reg <= bus_wr_i.data;
      if (soft_reset && pins_reset) pins_reset <= REG_RESET_VALUE[0];
      else if (wr_cfg && key_state == KEY_OPEN) pins_reset <= bus_wr_i.data[0];
      if (soft_reset && analog_reset) analog_reset <= REG_RESET_VALUE[0];
      else if (wr_analog) analog_reset <= bus_wr_i.data[0];
    end
  end

  // Tri-state window for the retained pin after a soft reset
  logic [$clog2(HIGHZ_CYCLES+1)-1:0] highz_cnt;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      highz_cnt <= '0;
    end else if (soft_reset && !pins_reset && !hard_reset) begin
      highz_cnt <= ($clog2(HIGHZ_CYCLES+1))'(HIGHZ_CYCLES);
    end else if (highz_cnt != '0) begin
      highz_cnt <= highz_cnt - 1'b1;
    end
  end

  // Outputs registered from the event cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      system_reset_o <= 1'b0;
      retention_o <= '0;
      wdog_enable_o <= 1'b1;
      pin_p3_4_oe_n_o <= 1'b0;
    end else begin
      system_reset_o <= hard_reset | soft_reset;
      retention_o.pins_reset <= hard_reset | (soft_reset & pins_reset);
      retention_o.analog_reset <= hard_reset | (soft_reset & analog_reset);
      retention_o.mmr_reset <= hard_reset | (soft_reset & pins_reset);
      retention_o.sram_valid <= ~por_i;
      if (hard_reset | soft_reset) wdog_enable_o <= 1'b1;
      pin_p3_4_oe_n_o <= (highz_cnt != '0) || (soft_reset && !pins_reset);
    end
  end

  // Read mux
  wire [15:0] rd_cfg = {15'h0000, pins_reset};
  wire [15:0] rd_cause = {12'h000, cause};
  wire [15:0] rd_analog = {15'h0000, analog_reset};
  always_comb begin
    if (bus_rd_addr_i == RETENTION_CONFIG_ADDR) bus_rd_data_o = rd_cfg;
    else if (bus_rd_addr_i == CONFIG_KEY_ADDR) bus_rd_data_o = key_reg;
    else if (bus_rd_addr_i == CAUSE_FLAGS_ADDR) bus_rd_data_o = rd_cause;
    else if (bus_rd_addr_i == ANALOG_RETENTION_ADDR) bus_rd_data_o = rd_analog;
    else bus_rd_data_o = 16'h0000;
  end

  // Checks
  // Key pair with one idle bus cycle between the two key writes
  sequence s_key_pair;
    wr_key && bus_wr_i.data == KEY_FIRST && key_state == KEY_LOCKED && !soft_reset && !hard_reset
      ##1 !bus_wr_i.wr && !soft_reset && !hard_reset
      ##1 wr_key && bus_wr_i.data == KEY_SECOND && !soft_reset && !hard_reset;
  endsequence
  // Soft reset while pins and logic are retained
  sequence s_soft_kept;
    soft_reset && !pins_reset && !hard_reset;
  endsequence
  // Soft reset while analog state is retained
  sequence s_analog_kept;
    soft_reset && !analog_reset && !hard_reset;
  endsequence
  a_key_unlock: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_key_pair |=> key_state == KEY_OPEN) else $error("key pair did not unlock");
  a_key_relock: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    key_state == KEY_OPEN && bus_wr_i.wr |=> key_state == KEY_LOCKED) else $error("no relock");
  a_cfg_locked: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    key_state != KEY_OPEN && !hard_reset && !soft_reset |=> $stable(pins_reset)) else $error("locked cfg changed");
  a_cause_set: assert property (@(posedge clk_sys_i)
    wdog_req && !por_i |=> cause[WDOG_BIT]) else $error("watchdog flag not set");
  a_cause_clear: assert property (@(posedge clk_sys_i)
    wr_cause && bus_wr_i.data[PIN_BIT] && !pin_sync && !por_i |=> !cause[PIN_BIT]) else $error("flag not cleared");
  a_soft_req: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    soft_req |=> system_reset_o && cause[SOFT_BIT]) else $error("soft reset missed");
  a_highz_win: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_soft_kept |=> pin_p3_4_oe_n_o [*8]) else $error("pin not tri-stated");
  a_sram_por: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    por_i |=> !retention_o.sram_valid) else $error("sram valid after por");
  a_wdog_on: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    hard_reset |=> wdog_enable_o) else $error("watchdog off after reset");

  // Every accepted cause raises the system reset one cycle later
  a_event_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    hard_reset || soft_reset |=> system_reset_o) else $error("reset event lost");

  // Power-on leaves exactly its own flag behind
  a_por_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    por_i |=> cause == 4'h1) else $error("power-on flags wrong");

  // Open key lets the config write land
  a_cfg_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_cfg && key_state == KEY_OPEN && !soft_reset && !hard_reset
      |=> pins_reset == $past(bus_wr_i.data[0])) else $error("config write lost");

  // Analog config has no key, any write lands
  a_analog_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_analog && !soft_reset && !hard_reset
      |=> analog_reset == $past(bus_wr_i.data[0])) else $error("analog write lost");

  // Half-open key drops on any write but the second key
  a_key_half_drop: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    key_state == KEY_HALF && bus_wr_i.wr && !(wr_key && bus_wr_i.data == KEY_SECOND) && !soft_reset
      |=> key_state == KEY_LOCKED) else $error("half key kept");

  // Hard resets reset pins, analog state and registers downstream
  a_hard_outputs: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    hard_reset |=> retention_o.pins_reset && retention_o.analog_reset && retention_o.mmr_reset)
    else $error("hard reset not applied");

  // Soft reset with retention disabled falls back to retained default
  a_soft_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    soft_reset && pins_reset && !hard_reset |=> !pins_reset) else $error("config not restored");

  // Retained pins and registers see no reset
  a_soft_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_soft_kept |=> !retention_o.pins_reset && !retention_o.mmr_reset) else $error("pins reset");

  // Retained analog state sees no reset
  a_analog_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_analog_kept |=> !retention_o.analog_reset) else $error("analog reset");

  // Any reset event relocks the key, so a stale unlock never survives
  a_reset_relock: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    soft_reset || hard_reset |=> key_state == KEY_LOCKED) else $error("key open after reset");
endmodule // reset_cause_and_retention_control

// [tb/core_bus_model.sv]
`timescale 1ns/10ps
// Core side of the register bus; drives 1 ns after each rising edge
module core_bus_model (
  input wire logic clk_sys_i,
  input wire logic [15:0] bus_rd_data_i,
  output reset_ctrl_pkg::reg_write_type bus_wr_o,
  output logic [31:0] bus_rd_addr_o,
  output logic core_ctrl_wr_o,
  output logic [31:0] core_ctrl_data_o
);
  import reset_ctrl_pkg::*;
  initial begin
    bus_wr_o = '0;
    bus_rd_addr_o = 32'h0000_0000;
    core_ctrl_wr_o = 1'b0;
    core_ctrl_data_o = 32'h0000_0000;
  end
  // Lines inverted on release so a stale value never looks valid
  task automatic write(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk_sys_i) #1 bus_wr_o = '{1'b1, a, d};
    @(posedge clk_sys_i) #1 bus_wr_o = '{1'b0, ~a, ~d};
  endtask
  // Key goes in the upper half of the core control word
  task automatic core_write(input logic [15:0] key);
    @(posedge clk_sys_i) #1 core_ctrl_wr_o = 1'b1;
    core_ctrl_data_o = {key, 16'h0000};
    @(posedge clk_sys_i) #1 core_ctrl_wr_o = 1'b0;
    core_ctrl_data_o = ~core_ctrl_data_o;
  endtask
  task automatic read(input logic [31:0] a, output logic [15:0] d);
    bus_rd_addr_o = a;
    #1 d = bus_rd_data_i;
  endtask
endmodule // core_bus_model

// [tb/reset_cause_and_retention_control_test.sv]
`timescale 1ns/10ps
// Short tri-state window keeps the run brief
module reset_cause_and_retention_control_test;
  import reset_ctrl_pkg::*;
  localparam int HZ = 20;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic por_i = 1'b0;
  logic pin_reset_n_i = 1'b1;
  logic wdog_timeout_i = 1'b0;
  reg_write_type bus_wr;
  logic core_wr, sys_rst, oe_n, wdog_en;
  logic [31:0] core_data, rd_addr;
  logic [15:0] rd_data, v;
  retention_out_type ret;
  int fails = 0;
  int checks = 0;
  int n;
  always #2 clk_sys_i = ~clk_sys_i;
  core_bus_model core (.clk_sys_i(clk_sys_i), .bus_rd_data_i(rd_data), .bus_wr_o(bus_wr),
    .bus_rd_addr_o(rd_addr), .core_ctrl_wr_o(core_wr), .core_ctrl_data_o(core_data));
  reset_cause_and_retention_control #(.HIGHZ_CYCLES(HZ)) uut (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .por_i(por_i), .pin_reset_n_i(pin_reset_n_i), .wdog_timeout_i(wdog_timeout_i),
    .core_ctrl_wr_i(core_wr), .core_ctrl_data_i(core_data), .bus_wr_i(bus_wr), .bus_rd_addr_i(rd_addr),
    .bus_rd_data_o(rd_data), .system_reset_o(sys_rst), .retention_o(ret), .pin_p3_4_oe_n_o(oe_n),
    .wdog_enable_o(wdog_en));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [15:0] exp);
    core.read(a, v);
    chk(v, exp);
  endtask
  task automatic unlock();
    core.write(CONFIG_KEY_ADDR, KEY_FIRST);
    core.write(CONFIG_KEY_ADDR, KEY_SECOND);
  endtask
  // Timeout pulse, then count the cycles the pin spends tri-stated
  task automatic wdog(input int hz, input logic [15:0] exp_ret);
    @(posedge clk_sys_i) #1 wdog_timeout_i = 1'b1;
    @(posedge clk_sys_i) #1 wdog_timeout_i = 1'b0;
    chk(16'(sys_rst), 16'h0001);
    chk(16'(wdog_en), 16'h0001);
    chk(16'(ret), exp_ret);
    n = 0;
    repeat (40) begin
      if (oe_n === 1'b1) n++;
      @(posedge clk_sys_i) #1;
    end
    chk(16'(n), 16'(hz));
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    por_i = 1'b1;
    @(posedge clk_sys_i) #1 por_i = 1'b0;
    rd(CAUSE_FLAGS_ADDR, 16'h0001);
    rd(RETENTION_CONFIG_ADDR, 16'h0000);
    rd(CONFIG_KEY_ADDR, 16'h0000);
    rd(ANALOG_RETENTION_ADDR, 16'h0000);
    rd(32'h4000_2444, 16'h0000);
    core.write(CAUSE_FLAGS_ADDR, 16'hFFFF);
    rd(CAUSE_FLAGS_ADDR, 16'h0000);
    core.write(RETENTION_CONFIG_ADDR, 16'h0001);
    rd(RETENTION_CONFIG_ADDR, 16'h0000);
    unlock();
    rd(CONFIG_KEY_ADDR, KEY_SECOND);
    core.write(ANALOG_RETENTION_ADDR, 16'h0001);
    core.write(RETENTION_CONFIG_ADDR, 16'h0001);
    rd(RETENTION_CONFIG_ADDR, 16'h0000);
    rd(ANALOG_RETENTION_ADDR, 16'h0001);
    unlock();
    core.write(RETENTION_CONFIG_ADDR, 16'h0001);
    rd(RETENTION_CONFIG_ADDR, 16'h0001);
    wdog(0, 16'h000F);
    rd(RETENTION_CONFIG_ADDR, 16'h0000);
    rd(ANALOG_RETENTION_ADDR, 16'h0000);
    rd(CAUSE_FLAGS_ADDR, 16'h0004);
    wdog(HZ + 1, 16'h0001);
    core.core_write(16'h05FB);
    rd(CAUSE_FLAGS_ADDR, 16'h0004);
    core.core_write(CORE_RESET_KEY);
    rd(CAUSE_FLAGS_ADDR, 16'h000C);
    @(posedge clk_sys_i) #1 pin_reset_n_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1 pin_reset_n_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rd(CAUSE_FLAGS_ADDR, 16'h000E);
    // Ordinary reset mid-run must not touch the cause flags
    #1 rst_n_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    rd(CAUSE_FLAGS_ADDR, 16'h000E);
    core.write(CAUSE_FLAGS_ADDR, 16'h0004);
    rd(CAUSE_FLAGS_ADDR, 16'h000A);
    @(posedge clk_sys_i) #1 por_i = 1'b1;
    @(posedge clk_sys_i) #1 por_i = 1'b0;
    chk(16'(ret), 16'h000E);
    rd(CAUSE_FLAGS_ADDR, 16'h0001);
    results();
  end
endmodule // reset_cause_and_retention_control_test
